// ===== rtsc_core_model.sv
/*
 * Behavioural core memory array that faces the controller's selection outputs.
 * Assumes the addressed word is read combinationally and is written while the write switches are on.
 */
`timescale 1ns/100ps
`default_nettype none
module rtsc_core_model (
    // Clock
    input wire logic i_clk,
    // Selection and data
    input wire logic [11:0] i_addr,
    input wire logic i_write_switches,
    input wire logic [11:0] i_inhibit,
    output logic [11:0] o_rdata
);
    logic [11:0] mem [0:4095];
    logic [11:0] addr_q;

    // Every word starts as a group-one operate instruction so a free run stays harmless.
    initial begin
        for (int a = 0; a < 4096; a++) begin
            mem[a] = 12'h007;
        end
    end

    assign o_rdata = mem[i_addr];

    // An inhibited plane keeps its zero, any other plane is set to one.
    // The write switches come one cycle after the request, when the address may already be the next one.
    always @(posedge i_clk) begin
        addr_q <= i_addr;
        if (i_write_switches) begin
            mem[addr_q] <= ~i_inhibit;
        end
    end
endmodule : rtsc_core_model
`default_nettype wire

// ===== rtsc_core_sel.sv
/*
 * Core memory Y-axis line decode, current-direction switches and inhibit drive.
 * Assumes read and write are never requested together by the controller.
 */
`timescale 1ns/100ps
`default_nettype none
module rtsc_core_sel (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Controller side
    rtsc_sel_if.sel s
);
    import rtsc_pkg::*;
    logic [63:0] nxt_y;
    logic nxt_r;
    logic nxt_w;
    logic [11:0] nxt_inh;
    logic [63:0] y_ff;
    logic r_ff;
    logic w_ff;
    logic [11:0] inh_ff;

    always_comb begin
        nxt_y = '0;
        if (s.rd || s.wr) begin
            nxt_y[s.addr[Y_LSB +: Y_W]] = 1'b1;
        end
        nxt_r = s.rd;
        nxt_w = s.wr && !s.rd;
        nxt_inh = (s.wr && !s.rd) ? ~s.wdata : 12'h000;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            y_ff <= '0;
            r_ff <= 1'b0;
            w_ff <= 1'b0;
            inh_ff <= 12'h000;
        end else begin
            y_ff <= nxt_y;
            r_ff <= nxt_r;
            w_ff <= nxt_w;
            inh_ff <= nxt_inh;
        end
    end

    assign s.y_line = y_ff;
    assign s.rd_sw = r_ff;
    assign s.wr_sw = w_ff;
    assign s.inhibit = inh_ff;

    property p_sel_one;
        @(posedge i_clk) disable iff (!i_arst_n) (s.rd || s.wr) |=> $onehot(y_ff) && y_ff[$past(s.addr[11:6])];
    endproperty
    a_sel_one: assert property (p_sel_one) else $error("Y line not decoded");
    property p_rd_pol;
        @(posedge i_clk) disable iff (!i_arst_n) s.rd |=> r_ff && !w_ff && inh_ff == 12'h000;
    endproperty
    a_rd_pol: assert property (p_rd_pol) else $error("Read polarity wrong");
    property p_wr_pol;
        @(posedge i_clk) disable iff (!i_arst_n) (s.wr && !s.rd) |=> w_ff && !r_ff;
    endproperty
    a_wr_pol: assert property (p_wr_pol) else $error("Write polarity wrong");
    property p_inh;
        @(posedge i_clk) disable iff (!i_arst_n) (s.wr && !s.rd) |=> inh_ff == ~$past(s.wdata);
    endproperty
    a_inh: assert property (p_inh) else $error("Inhibit mismatch");
    c_wr: cover property (@(posedge i_clk) disable iff (!i_arst_n) s.wr ##1 w_ff);
endmodule : rtsc_core_sel
`default_nettype wire

// ===== rtsc_ctrl.sv
/*
 * Register-transfer and major-state control for a 12-bit processor with core memory.
 * Assumes one processor clock, console keys as asynchronous levels, and memory data valid at time state one.
 */
`timescale 1ns/100ps
`default_nettype none
module rtsc_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Console
    input wire logic i_load_address_key,
    input wire logic i_run_key,
    input wire logic i_peek_key,
    input wire logic i_deposit_key,
    input wire logic [rtsc_pkg::WORD_W-1:0] i_console_switches,
    // Data-break request and core read data
    input wire logic i_break_req,
    input wire logic [rtsc_pkg::WORD_W-1:0] i_mem_rdata,
    // Core selection
    output logic [63:0] o_y_line,
    output logic o_read_switches,
    output logic o_write_switches,
    output logic [rtsc_pkg::WORD_W-1:0] o_inhibit,
    // Visible state
    output logic [rtsc_pkg::WORD_W-1:0] o_program_counter,
    output logic [rtsc_pkg::WORD_W-1:0] o_memory_address_reg,
    output logic [rtsc_pkg::WORD_W-1:0] o_memory_buffer_reg,
    output logic [rtsc_pkg::WORD_W-1:0] o_working_register,
    output logic [2:0] o_instruction_register,
    output logic [7:0] o_instr_decode,
    output rtsc_pkg::rtsc_major_t o_major_state,
    output rtsc_pkg::rtsc_tstate_t o_time_state,
    output logic o_running
);
    import rtsc_pkg::*;
    // ------------------------------------------------------------
    // Key synchronisers
    // ------------------------------------------------------------
    logic [3:0] key_raw, key_rise;
    logic [3:0] k1_ff, k2_ff, k3_ff, kst_ff, nxt_kst;
    assign key_raw = {i_deposit_key, i_peek_key, i_run_key, i_load_address_key};
    always_comb begin
        nxt_kst = ((k2_ff ~^ k3_ff) & k3_ff) | ((k2_ff ^ k3_ff) & kst_ff);
    end
    assign key_rise = nxt_kst & ~kst_ff;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            k1_ff <= 4'h0;
            k2_ff <= 4'h0;
            k3_ff <= 4'h0;
            kst_ff <= 4'h0;
        end else begin
            k1_ff <= key_raw;
            k2_ff <= k1_ff;
            k3_ff <= k2_ff;
            kst_ff <= nxt_kst;
        end
    end
    // ------------------------------------------------------------
    // Transfer network
    // ------------------------------------------------------------
    logic [11:0] pc_ff, ma_ff, mb_ff, ac_ff;
    logic [2:0] ir_ff;
    rtsc_major_t ms_ff;
    rtsc_tstate_t ts_ff;
    rtsc_manual_t mn_ff;
    logic [3:0] key_ff;
    logic run_ff;
    rtsc_src_t src;
    rtsc_route_t route;
    logic carry_in, ld_pc, ld_ma, ld_mb, ld_ac;
    logic [11:0] bus_in, sum, bus_out;
    logic [7:0] dec;
    always_comb begin
        case (src)
            RTSC_SRC_PC: bus_in = pc_ff;
            RTSC_SRC_MA: bus_in = ma_ff;
            RTSC_SRC_SW: bus_in = i_console_switches;
            RTSC_SRC_MEM: bus_in = i_mem_rdata;
            RTSC_SRC_AC: bus_in = ac_ff;
            RTSC_SRC_MB: bus_in = mb_ff;
            default: bus_in = 12'h000;
        endcase
        sum = bus_in + {11'h000, carry_in};
        case (route)
            RTSC_RT_STRAIGHT: bus_out = sum;
            RTSC_RT_SHL: bus_out = {sum[10:0], 1'b0};
            RTSC_RT_SHR: bus_out = {1'b0, sum[11:1]};
            RTSC_RT_ROL: bus_out = {sum[10:0], sum[11]};
            RTSC_RT_ROR: bus_out = {sum[0], sum[11:1]};
            default: bus_out = sum;
        endcase
        dec = 8'h01 << ir_ff;
    end
    // ------------------------------------------------------------
    // Sequencing: manual and processor time states
    // ------------------------------------------------------------
    rtsc_major_t nxt_ms;
    rtsc_tstate_t nxt_ts;
    rtsc_manual_t nxt_mn;
    logic [3:0] nxt_key;
    logic nxt_run, mem_rd, mem_wr;
    always_comb begin
        nxt_ms = ms_ff;
        nxt_ts = ts_ff;
        nxt_mn = mn_ff;
        nxt_key = key_ff;
        nxt_run = run_ff;
        src = RTSC_SRC_NONE;
        route = RTSC_RT_STRAIGHT;
        carry_in = 1'b0;
        ld_pc = 1'b0;
        ld_ma = 1'b0;
        ld_mb = 1'b0;
        ld_ac = 1'b0;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        case (mn_ff)
            RTSC_MN_IDLE: begin
                if (!run_ff && key_rise != 4'h0 && ts_ff == RTSC_TS_IDLE) begin
                    nxt_key = key_rise;
                    nxt_mn = RTSC_MN_ZERO;
                end
            end
            RTSC_MN_ZERO: begin
                nxt_ms = RTSC_MS_NONE;
                nxt_mn = RTSC_MN_ONE;
            end
            RTSC_MN_ONE: begin
                if (key_ff[3:1] != 3'h0) begin
                    src = RTSC_SRC_PC;
                    route = RTSC_RT_STRAIGHT;
                    ld_ma = 1'b1;
                end
                nxt_mn = RTSC_MN_TWO;
            end
            RTSC_MN_TWO: begin
                nxt_mn = RTSC_MN_IDLE;
                if (key_ff[0]) begin
                    src = RTSC_SRC_SW;
                    ld_pc = 1'b1;
                end else if (key_ff[1]) begin
                    nxt_ms = RTSC_MS_FETCH;
                    nxt_run = 1'b1;
                    nxt_ts = RTSC_TS_1;
                end else begin
                    src = RTSC_SRC_MA;
                    carry_in = 1'b1;
                    ld_pc = 1'b1;
                    nxt_ts = RTSC_TS_1;
                end
            end
            default: nxt_mn = RTSC_MN_IDLE;
        endcase
        if (mn_ff != RTSC_MN_TWO) begin
            case (ts_ff)
                RTSC_TS_1: begin
                    mem_rd = 1'b1;
                    src = (!run_ff && key_ff[3]) ? RTSC_SRC_SW : RTSC_SRC_MEM;
                    ld_mb = 1'b1;
                    nxt_ts = RTSC_TS_2;
                end
                RTSC_TS_2: begin
                    if (run_ff && ms_ff == RTSC_MS_FETCH) begin
                        src = RTSC_SRC_PC;
                        carry_in = 1'b1;
                        ld_pc = 1'b1;
                    end
                    nxt_ts = RTSC_TS_3;
                end
                RTSC_TS_3: begin
                    if (run_ff && ms_ff == RTSC_MS_FETCH && ir_ff == OPC_OPR && !mb_ff[B08]) begin
                        if (!mb_ff[B04] && !mb_ff[B06]) begin
                            src = RTSC_SRC_AC;
                            ld_ac = 1'b1;
                        end else if (mb_ff[B06]) begin
                            src = RTSC_SRC_AC;
                            route = mb_ff[B03] ? RTSC_RT_ROL : RTSC_RT_ROR;
                            ld_ac = 1'b1;
                        end
                    end
                    nxt_ts = RTSC_TS_4;
                end
                RTSC_TS_4: begin
                    mem_wr = 1'b1;
                    if (!run_ff) begin
                        nxt_ts = RTSC_TS_IDLE;
                    end else begin
                        if (i_break_req) begin
                            nxt_ms = RTSC_MS_WC;
                        end else begin
                            case (ms_ff)
                                RTSC_MS_FETCH: nxt_ms = (ir_ff == OPC_OPR) ? RTSC_MS_FETCH
                                    : (mb_ff[B08] ? RTSC_MS_DEFER : RTSC_MS_EXEC);
                                RTSC_MS_DEFER: nxt_ms = RTSC_MS_EXEC;
                                RTSC_MS_WC: nxt_ms = RTSC_MS_CA;
                                RTSC_MS_CA: nxt_ms = RTSC_MS_BRK;
                                default: nxt_ms = RTSC_MS_FETCH;
                            endcase
                        end
                        src = RTSC_SRC_PC;
                        ld_ma = 1'b1;
                        nxt_ts = RTSC_TS_1;
                    end
                end
                default: nxt_ts = ts_ff;
            endcase
        end
    end
    logic [11:0] nxt_pc, nxt_ma, nxt_mb, nxt_ac;
    logic [2:0] nxt_ir;
    always_comb begin
        nxt_pc = ld_pc ? bus_out : pc_ff;
        nxt_ma = ld_ma ? bus_out : ma_ff;
        nxt_mb = ld_mb ? bus_out : mb_ff;
        nxt_ac = ld_ac ? bus_out : ac_ff;
        nxt_ir = ir_ff;
        if (run_ff && ms_ff == RTSC_MS_FETCH && ts_ff == RTSC_TS_1) begin
            nxt_ir = i_mem_rdata[OPC_LSB +: OPC_W];
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pc_ff <= WORD_RST;
            ma_ff <= WORD_RST;
            mb_ff <= WORD_RST;
            ac_ff <= WORD_RST;
            ir_ff <= 3'h0;
            ms_ff <= RTSC_MS_NONE;
            ts_ff <= RTSC_TS_IDLE;
            mn_ff <= RTSC_MN_IDLE;
            key_ff <= 4'h0;
            run_ff <= 1'b0;
        end else begin
            pc_ff <= nxt_pc;
            ma_ff <= nxt_ma;
            mb_ff <= nxt_mb;
            ac_ff <= nxt_ac;
            ir_ff <= nxt_ir;
            ms_ff <= nxt_ms;
            ts_ff <= nxt_ts;
            mn_ff <= nxt_mn;
            key_ff <= nxt_key;
            run_ff <= nxt_run;
        end
    end
    // ------------------------------------------------------------
    // Core selection
    // ------------------------------------------------------------
    rtsc_sel_if sel_bus ();
    assign sel_bus.addr = ma_ff;
    assign sel_bus.rd = mem_rd;
    assign sel_bus.wr = mem_wr;
    assign sel_bus.wdata = mb_ff;
    rtsc_core_sel i_rtsc_core_sel (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .s(sel_bus.sel)
    );
    assign o_y_line = sel_bus.y_line;
    assign o_read_switches = sel_bus.rd_sw;
    assign o_write_switches = sel_bus.wr_sw;
    assign o_inhibit = sel_bus.inhibit;
    assign o_program_counter = pc_ff;
    assign o_memory_address_reg = ma_ff;
    assign o_memory_buffer_reg = mb_ff;
    assign o_working_register = ac_ff;
    assign o_instruction_register = ir_ff;
    assign o_instr_decode = dec;
    assign o_major_state = ms_ff;
    assign o_time_state = ts_ff;
    assign o_running = run_ff;
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ir_fetch;
        @(posedge i_clk) disable iff (!i_arst_n) (run_ff && ms_ff == RTSC_MS_FETCH && ts_ff == RTSC_TS_1)
            |=> ir_ff == $past(i_mem_rdata[2:0]);
    endproperty
    a_ir_fetch: assert property (p_ir_fetch) else $error("IR not loaded in fetch");
    property p_dec;
        @(posedge i_clk) disable iff (!i_arst_n) $onehot(dec) && dec[ir_ff];
    endproperty
    a_dec: assert property (p_dec) else $error("Decode not one-hot");
    property p_strobe;
        @(posedge i_clk) disable iff (!i_arst_n) ts_ff == RTSC_TS_1 && mn_ff != RTSC_MN_TWO |=> o_read_switches;
    endproperty
    a_strobe: assert property (p_strobe) else $error("No read in T1");
    property p_clr;
        @(posedge i_clk) disable iff (!i_arst_n) mn_ff == RTSC_MN_ZERO |=> ms_ff == RTSC_MS_NONE;
    endproperty
    a_clr: assert property (p_clr) else $error("Major state not cleared");
    property p_la;
        @(posedge i_clk) disable iff (!i_arst_n) (mn_ff == RTSC_MN_TWO && key_ff[0])
            |=> pc_ff == $past(i_console_switches);
    endproperty
    a_la: assert property (p_la) else $error("Load address failed");
    property p_hold;
        @(posedge i_clk) disable iff (!i_arst_n) !ld_ma |=> ma_ff == $past(ma_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("MA changed without load");
    property p_pcma;
        @(posedge i_clk) disable iff (!i_arst_n) (src == RTSC_SRC_PC && ld_ma && route == RTSC_RT_STRAIGHT)
            |=> ma_ff == $past(pc_ff);
    endproperty
    a_pcma: assert property (p_pcma) else $error("PC to MA failed");
    property p_skip;
        @(posedge i_clk) disable iff (!i_arst_n) (ts_ff == RTSC_TS_3 && (mb_ff[B04] || mb_ff[B06]) && !ld_ac)
            |=> ac_ff == $past(ac_ff) && ts_ff == RTSC_TS_4;
    endproperty
    a_skip: assert property (p_skip) else $error("Skipped event altered AC");
    c_run: cover property (@(posedge i_clk) disable iff (!i_arst_n) mn_ff == RTSC_MN_TWO && key_ff[1]);
    c_dep: cover property (@(posedge i_clk) disable iff (!i_arst_n) ts_ff == RTSC_TS_1 && key_ff[3]);
    c_opr: cover property (@(posedge i_clk) disable iff (!i_arst_n) ld_ac && ts_ff == RTSC_TS_3);
endmodule : rtsc_ctrl
`default_nettype wire

// ===== rtsc_ctrl_test.sv
/*
 * Self-checking bench for the register-transfer and state control block.
 * Assumes the core memory model beside it and console keys pressed one at a time.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module rtsc_ctrl_test;
    import rtsc_pkg::*;
    logic i_clk;
    logic i_arst_n;
    logic [3:0] keys;
    logic [11:0] i_console_switches;
    logic i_break_req;
    logic [11:0] i_mem_rdata;
    logic [63:0] o_y_line;
    logic o_read_switches;
    logic o_write_switches;
    logic [11:0] o_inhibit;
    logic [11:0] o_program_counter;
    logic [11:0] o_memory_address_reg;
    logic [11:0] o_memory_buffer_reg;
    logic [11:0] o_working_register;
    logic [2:0] o_instruction_register;
    logic [7:0] o_instr_decode;
    rtsc_major_t o_major_state;
    rtsc_tstate_t o_time_state;
    logic o_running;
    int bad_count = 0;
    int checks = 0;
    logic [11:0] addr_tab [3] = '{12'h000, 12'h0c5, 12'hfc0};
    logic [11:0] data_tab [3] = '{12'h000, 12'h5a3, 12'hfff};

    rtsc_ctrl i_rtsc_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_load_address_key(keys[0]),
        .i_run_key(keys[1]), .i_peek_key(keys[2]), .i_deposit_key(keys[3]),
        .i_console_switches(i_console_switches), .i_break_req(i_break_req), .i_mem_rdata(i_mem_rdata),
        .o_y_line(o_y_line), .o_read_switches(o_read_switches), .o_write_switches(o_write_switches),
        .o_inhibit(o_inhibit), .o_program_counter(o_program_counter),
        .o_memory_address_reg(o_memory_address_reg), .o_memory_buffer_reg(o_memory_buffer_reg),
        .o_working_register(o_working_register), .o_instruction_register(o_instruction_register),
        .o_instr_decode(o_instr_decode), .o_major_state(o_major_state), .o_time_state(o_time_state),
        .o_running(o_running));
    rtsc_core_model i_rtsc_core_model (.i_clk(i_clk), .i_addr(o_memory_address_reg),
        .i_write_switches(o_write_switches), .i_inhibit(o_inhibit), .o_rdata(i_mem_rdata));

    always #5 i_clk = ~i_clk;

    task automatic wrap_up();
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk);
            #1;
        end
    endtask : tick

    task automatic press(input int k);
        keys[k] = 1'b1;
        tick(2);
        keys[k] = 1'b0;
    endtask : press

    task automatic wait_ts(input rtsc_tstate_t v);
        int n;
        n = 0;
        while (o_time_state !== v && n < 40) begin
            tick(1);
            n++;
        end
        `CHK("time_state", v, o_time_state)
    endtask : wait_ts

    task automatic wait_ms(input rtsc_major_t v);
        int n;
        n = 0;
        while (o_major_state !== v && n < 60) begin
            tick(1);
            n++;
        end
        `CHK("major_state", v, o_major_state)
    endtask : wait_ms

    task automatic load_addr(input logic [11:0] a);
        i_console_switches = a;
        press(0);
        tick(12);
        `CHK("pc_load", a, o_program_counter)
        `CHK("ms_clear", RTSC_MS_NONE, o_major_state)
    endtask : load_addr

    // Deposit or examine walk; the switches hold the inverse word when examining.
    task automatic mem_key(input int k, input logic [11:0] a, input logic [11:0] d);
        i_console_switches = (k == 3) ? d : ~d;
        press(k);
        wait_ts(RTSC_TS_1);
        `CHK("ma", a, o_memory_address_reg)
        `CHK("pc_inc", 12'(a + 12'h001), o_program_counter)
        tick(1);
        `CHK("mb", d, o_memory_buffer_reg)
        `CHK("read_sw", 1'b1, o_read_switches)
        `CHK("ts2", RTSC_TS_2, o_time_state)
        tick(1);
        `CHK("ts3", RTSC_TS_3, o_time_state)
        tick(1);
        `CHK("ts4", RTSC_TS_4, o_time_state)
        tick(1);
        `CHK("write_sw", 1'b1, o_write_switches)
        `CHK("inhibit", ~d, o_inhibit)
        `CHK("y_line", 64'h1 << a[11:6], o_y_line)
        `CHK("ts_idle", RTSC_TS_IDLE, o_time_state)
    endtask : mem_key

    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end

    initial begin
        i_clk = 1'b0;
        i_arst_n = 1'b0;
        keys = 4'h0;
        i_console_switches = 12'h000;
        i_break_req = 1'b0;
        tick(3);
        i_arst_n = 1'b1;
        tick(2);
        `CHK("rst_pc", 12'h000, o_program_counter)
        `CHK("rst_mb", 12'h000, o_memory_buffer_reg)
        `CHK("rst_run", 1'b0, o_running)
        `CHK("rst_y", 64'h0, o_y_line)
        for (int i = 0; i < 3; i++) begin
            load_addr(addr_tab[i]);
            mem_key(3, addr_tab[i], data_tab[i]);
        end
        for (int i = 0; i < 3; i++) begin
            load_addr(addr_tab[i]);
            mem_key(2, addr_tab[i], data_tab[i]);
        end
        load_addr(12'h010);
        press(1);
        wait_ts(RTSC_TS_1);
        `CHK("running", 1'b1, o_running)
        `CHK("fetch", RTSC_MS_FETCH, o_major_state)
        tick(1);
        `CHK("ir", 3'h7, o_instruction_register)
        `CHK("decode", 8'h80, o_instr_decode)
        tick(2);
        `CHK("pc_run", 12'h011, o_program_counter)
        `CHK("ac_kept", 12'h000, o_working_register)
        i_break_req = 1'b1;
        wait_ms(RTSC_MS_WC);
        i_break_req = 1'b0;
        wait_ms(RTSC_MS_CA);
        wait_ms(RTSC_MS_BRK);
        wait_ms(RTSC_MS_FETCH);
        i_console_switches = 12'h333;
        press(0);
        tick(12);
        `CHK("key_ignored", 1'b1, o_running)
        `CHK("ms_kept", 1'b1, o_major_state !== RTSC_MS_NONE)
        wrap_up();
    end
endmodule : rtsc_ctrl_test
`default_nettype wire

// ===== rtsc_pkg.sv
/*
 * Shared constants and types for the register-transfer and state control block.
 * Assumes a 12-bit word machine with a 64-line Y axis selected from address bits 6 to 11.
 */
package rtsc_pkg;
    localparam int WORD_W = 12;
    localparam int Y_LSB = 6;
    localparam int Y_W = 6;
    localparam int Y_LINES = 64;
    localparam int OPC_LSB = 0;
    localparam int OPC_W = 3;
    localparam int B04 = 4;
    localparam int B06 = 6;
    localparam int B03 = 3;
    localparam int B08 = 8;
    localparam logic [11:0] WORD_RST = 12'h000;
    localparam logic [2:0] OPC_OPR = 3'h7;
    // Selects the bus source; one value at a time, so there is one driver.
    typedef enum logic [2:0] {
        RTSC_SRC_NONE = 3'h0,
        RTSC_SRC_PC   = 3'h1,
        RTSC_SRC_MA   = 3'h2,
        RTSC_SRC_SW   = 3'h3,
        RTSC_SRC_MEM  = 3'h4,
        RTSC_SRC_AC   = 3'h5,
        RTSC_SRC_MB   = 3'h6
    } rtsc_src_t;
    // Exactly one adder output routing is active.
    typedef enum logic [2:0] {
        RTSC_RT_STRAIGHT = 3'h0,
        RTSC_RT_SHL      = 3'h1,
        RTSC_RT_SHR      = 3'h2,
        RTSC_RT_ROL      = 3'h3,
        RTSC_RT_ROR      = 3'h4
    } rtsc_route_t;
    typedef enum logic [2:0] {
        RTSC_MS_NONE  = 3'h0,
        RTSC_MS_FETCH = 3'h1,
        RTSC_MS_DEFER = 3'h3,
        RTSC_MS_EXEC  = 3'h2,
        RTSC_MS_WC    = 3'h6,
        RTSC_MS_CA    = 3'h7,
        RTSC_MS_BRK   = 3'h5
    } rtsc_major_t;
    typedef enum logic [2:0] {
        RTSC_TS_IDLE = 3'h0,
        RTSC_TS_1    = 3'h1,
        RTSC_TS_2    = 3'h3,
        RTSC_TS_3    = 3'h2,
        RTSC_TS_4    = 3'h6
    } rtsc_tstate_t;
    typedef enum logic [1:0] {
        RTSC_MN_IDLE = 2'h0,
        RTSC_MN_ZERO = 2'h1,
        RTSC_MN_ONE  = 2'h3,
        RTSC_MN_TWO  = 2'h2
    } rtsc_manual_t;
endpackage : rtsc_pkg

// ===== rtsc_sel_if.sv
/*
 * Carrier between the controller and the core selection module.
 * Assumes both ends run on the single processor clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface rtsc_sel_if;
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [11:0] wdata;
    logic [63:0] y_line;
    logic rd_sw;
    logic wr_sw;
    logic [11:0] inhibit;
    modport ctl (output addr, rd, wr, wdata, input y_line, rd_sw, wr_sw, inhibit);
    modport sel (input addr, rd, wr, wdata, output y_line, rd_sw, wr_sw, inhibit);
endinterface : rtsc_sel_if
`default_nettype wire
